// ### verilog/octal_rmii_port_interface.v
// eight-port rmii mac-side interface with management clock edges
`timescale 1ns/10ps
`default_nettype none
`include "rmii_regs.vh"

//Contract
//RL1: every port's transmit and receive timing follows one shared 50 MHz reference clock.
//RL2: transmit dibits change only on reference clock edges, one symbol per cycle.
//RL3: phy takes transmit dibits whenever transmit enable is high, ignores them otherwise.
//RL4: transmit enable is high exactly while valid frame dibits are presented.
//RL5: phy changes receive dibits only in step with the reference clock.
//RL6: each reference cycle with carrier-valid high captures two receive bits.
//RL7: carrier-valid may rise asynchronously, so it is synchronised before use.
//RL8: reset acts immediately, without waiting for a clock edge.
//RL9: device drives management clock and shifts management data on its rising edges.
//RL10: management data line is driven and sampled on management clock rising edges.
//RL11: each frame sends seven preamble bytes, start delimiter, data, four-byte checksum.
//RL12: ports a to h each own transmit pair, enable, receive pair, carrier-valid.
//RL13: core logic runs on its own clock; reference clock domain crosses safely.
module octal_rmii_port_interface (
   input wire clk,                     // core clock, 100 MHz
   input wire rst,                     // async reset, active high
   input wire rmii_ref_clock,          // shared 50 MHz reference from pin
   input wire [15:0] rxd,              // receive dibits, port a in [1:0]
   input wire [7:0] carrier_rx_valid_in, // carrier sense / rx valid per port
   input wire [63:0] tx_data,          // byte to send, port a in [7:0]
   input wire [7:0] tx_valid,          // byte offered per port
   input wire [7:0] tx_last,           // offered byte ends the frame
   output reg [7:0] tx_ready,          // one-cycle pulse: byte taken
   output reg [15:0] txd,              // transmit dibits to phys
   output reg [7:0] tx_enable_out,     // transmit enable per port
   output wire [63:0] rx_data,         // received byte per port
   output wire [7:0] rx_valid,         // received byte valid
   input wire [7:0] rx_ready,          // core accepts received byte
   output reg [7:0] rx_overflow,       // one-cycle pulse: byte lost
   output reg [7:0] rx_carrier,        // synchronised carrier-valid level
   output reg mdc,                     // management clock out
   output reg mdio_o,                  // management data drive value
   output reg mdio_oe_n,               // low while we drive management data
   input wire mdio_i,                  // management data pin level
   input wire mgmt_out_bit,            // next bit to shift out
   input wire mgmt_drive,              // we own the data line
   output reg mgmt_in_bit,             // bit sampled at last rising edge
   output reg mgmt_edge                // one-cycle pulse per rising edge
);
   localparam [3:0] ST_IDLE = 4'b0001;
   localparam [3:0] ST_PRE = 4'b0010;
   localparam [3:0] ST_DATA = 4'b0100;
   localparam [3:0] ST_FCS = 4'b1000;
   // counts worked out at integer width, then cut to the counter width on purpose
   localparam integer MDC_LAST_I = `MDC_HALF_CYCLES - 1;
   localparam integer IPG_LAST_I = `IPG_DIBITS - 1;
   localparam [5:0] MDC_LAST = MDC_LAST_I[5:0];
   localparam [5:0] IPG_LAST = IPG_LAST_I[5:0];

   reg ref_s1, ref_s2, ref_s3;
   reg [15:0] rxd_s1, rxd_s2;
   reg [7:0] crs_s1, crs_s2;
   reg mdio_s1, mdio_s2;
   reg [5:0] mdc_cnt;
   wire tx_tick;
   wire rx_tick;

   // one crc32 step over a dibit, low bit first as on the wire
   function [31:0] crc_dibit;
      input [31:0] c;
      input [1:0] d;
      integer i;
      reg [31:0] r;
      begin
         r = c;
         for (i = 0; i < 2; i = i + 1) begin
            if (r[0] ^ d[i])
               r = (r >> 1) ^ `CRC_POLY;
            else
               r = r >> 1;
         end
         crc_dibit = r;
      end
   endfunction

   // pin inputs pass two flops; third ref stage only feeds the edge detect
   always @(posedge clk or posedge rst) begin // [RL8]
      if (rst) begin
         ref_s1 <= 1'b0;
         ref_s2 <= 1'b0;
         ref_s3 <= 1'b0;
         rxd_s1 <= 16'h0000;
         rxd_s2 <= 16'h0000;
         crs_s1 <= 8'h00;
         crs_s2 <= 8'h00;
         mdio_s1 <= 1'b0;
         mdio_s2 <= 1'b0;
      end else begin
         ref_s1 <= rmii_ref_clock; // [RL13]
         ref_s2 <= ref_s1;
         ref_s3 <= ref_s2;
         rxd_s1 <= rxd;
         rxd_s2 <= rxd_s1;
         crs_s1 <= carrier_rx_valid_in; // [RL7]
         crs_s2 <= crs_s1;
         mdio_s1 <= mdio_i;
         mdio_s2 <= mdio_s1;
      end
   end

   // launch on the reference rising edge, sample mid-cycle on its falling
   // edge so receive data that just changed at the rising edge has settled
   assign tx_tick = ref_s2 & ~ref_s3; // [RL1]
   assign rx_tick = ~ref_s2 & ref_s3; // [RL5]

   // management clock divider; data moves only as mdc rises
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         mdc_cnt <= 6'h00;
         mdc <= 1'b0;
         mdio_o <= 1'b0;
         mdio_oe_n <= 1'b1;
         mgmt_in_bit <= 1'b0;
         mgmt_edge <= 1'b0;
      end else begin
         mgmt_edge <= 1'b0;
         if (mdc_cnt == MDC_LAST) begin
            mdc_cnt <= 6'h00;
            mdc <= ~mdc; // [RL9]
            if (!mdc) begin
               mdio_o <= mgmt_out_bit; // [RL10]
               mdio_oe_n <= ~mgmt_drive;
               mgmt_in_bit <= mdio_s2; // [RL10]
               mgmt_edge <= 1'b1;
            end
         end else begin
            mdc_cnt <= mdc_cnt + 6'h01;
         end
      end
   end

   genvar p;
   generate
      for (p = 0; p < 8; p = p + 1) begin : port // [RL12]
         reg [3:0] st;
         reg [31:0] sh;
         reg [3:0] dib;
         reg [2:0] cnt;
         reg [31:0] crc;
         reg fin;
         reg [5:0] gap;
         reg [7:0] rsr;
         reg [1:0] rdc;
         reg [7:0] push_d;
         reg push_v;
         wire push_ready;
         wire [31:0] crc_nx;
         wire [31:0] crc_use;

         assign crc_nx = crc_dibit(crc, sh[1:0]);
         // checksum covers data dibits only
         assign crc_use = st[2] ? crc_nx : crc;

         // transmit framer, advanced once per reference cycle
         always @(posedge clk or posedge rst) begin
            if (rst) begin
               st <= ST_IDLE;
               sh <= 32'h0000_0000;
               dib <= 4'h0;
               cnt <= 3'h0;
               crc <= `CRC_INIT;
               fin <= 1'b0;
               gap <= 6'h00;
               tx_ready[p] <= 1'b0;
               txd[2*p +: 2] <= 2'h0;
               tx_enable_out[p] <= 1'b0;
            end else begin
               tx_ready[p] <= 1'b0;
               if (tx_tick) begin // [RL2]
                  case (st)
                     ST_IDLE: begin
                        txd[2*p +: 2] <= 2'h0;
                        tx_enable_out[p] <= 1'b0; // [RL4]
                        if (gap != 6'h00) begin
                           gap <= gap - 6'h01;
                        end else if (tx_valid[p]) begin
                           st <= ST_PRE; // [RL11]
                           sh <= {24'h00_0000, `PREAMBLE_BYTE};
                           dib <= 4'h0;
                           cnt <= 3'h0;
                           crc <= `CRC_INIT;
                           fin <= 1'b0;
                        end
                     end
                     ST_PRE, ST_DATA: begin
                        txd[2*p +: 2] <= sh[1:0];
                        tx_enable_out[p] <= 1'b1; // [RL4]
                        sh <= sh >> 2;
                        dib <= dib + 4'h1;
                        crc <= crc_use;
                        if (dib[1:0] == 2'h3) begin
                           if (st[1] && cnt < `PREAMBLE_LAST) begin
                              sh <= {24'h00_0000, `PREAMBLE_BYTE}; // [RL11]
                              cnt <= cnt + 3'h1;
                           end else if (st[1] && cnt == `PREAMBLE_LAST) begin
                              sh <= {24'h00_0000, `SFD_BYTE}; // [RL11]
                              cnt <= `SFD_INDEX;
                           end else if (tx_valid[p] && !fin) begin
                              st <= ST_DATA;
                              sh <= {24'h00_0000, tx_data[8*p +: 8]};
                              tx_ready[p] <= 1'b1;
                              fin <= tx_last[p];
                           end else begin
                              // last byte sent or the core ran dry: close the frame
                              st <= ST_FCS; // [RL11]
                              sh <= ~crc_use;
                              dib <= 4'h0;
                           end
                        end
                     end
                     ST_FCS: begin
                        txd[2*p +: 2] <= sh[1:0];
                        tx_enable_out[p] <= 1'b1;
                        sh <= sh >> 2;
                        dib <= dib + 4'h1;
                        if (dib == `FCS_LAST_DIBIT) begin
                           st <= ST_IDLE;
                           gap <= IPG_LAST;
                        end
                     end
                     default: begin
                        st <= ST_IDLE;
                     end
                  endcase
               end
            end
         end

         // receive assembly: dibits arrive low pair first
         always @(posedge clk or posedge rst) begin
            if (rst) begin
               rsr <= 8'h00;
               rdc <= 2'h0;
               push_d <= 8'h00;
               push_v <= 1'b0;
               rx_carrier[p] <= 1'b0;
               rx_overflow[p] <= 1'b0;
            end else begin
               // buffer takes push_v at once unless both entries are full
               push_v <= push_v & ~push_ready;
               rx_overflow[p] <= 1'b0;
               if (rx_tick) begin
                  rx_carrier[p] <= crs_s2[p];
                  if (crs_s2[p]) begin
                     rsr <= {rxd_s2[2*p +: 2], rsr[7:2]}; // [RL6]
                     rdc <= rdc + 2'h1;
                     if (rdc == 2'h3) begin
                        push_d <= {rxd_s2[2*p +: 2], rsr[7:2]};
                        push_v <= 1'b1;
                        // a word still pending is overwritten: flag the loss
                        rx_overflow[p] <= push_v & ~push_ready;
                     end
                  end else begin
                     rdc <= 2'h0;
                  end
               end
            end
         end

         rx_pair_buffer #(
            .W(8)
         ) rx_buf (
            .clk(clk),
            .rst(rst),
            .in_data(push_d),
            .in_valid(push_v),
            .in_ready(push_ready),
            .out_data(rx_data[8*p +: 8]),
            .out_valid(rx_valid[p]),
            .out_ready(rx_ready[p])
         );
      end
   endgenerate
endmodule
`default_nettype wire

// ### verilog/rmii_regs.vh
// constants for the octal rmii port interface
`ifndef RMII_REGS_VH
`define RMII_REGS_VH

// clock figures
`define CLK_PERIOD_NS 10
`define REF_CLOCK_MHZ 50
// management clock period and derived half period in clk cycles
`define MDC_PERIOD_NS 400
`define MDC_HALF_CYCLES (`MDC_PERIOD_NS / (2 * `CLK_PERIOD_NS))

// frame framing: bytes as they leave lsb first (wire order 10101010 / 10101011)
`define PREAMBLE_BYTE 8'h55
`define SFD_BYTE 8'hD5
`define PREAMBLE_LAST 3'h6
`define SFD_INDEX 3'h7
`define FCS_LAST_DIBIT 4'hF
// inter frame gap of 96 bit times, in dibits
`define IPG_DIBITS 48

// ethernet crc32, reflected form
`define CRC_INIT 32'hFFFF_FFFF
`define CRC_POLY 32'hEDB8_8320

`endif

// ### verilog/rx_pair_buffer.v
// two-entry valid/ready buffer with registered outputs
`timescale 1ns/10ps
`default_nettype none
module rx_pair_buffer #(
   parameter W = 8
) (
   input wire clk,              // core clock
   input wire rst,              // async reset, active high
   input wire [W-1:0] in_data,  // word offered
   input wire in_valid,         // word offered valid
   output wire in_ready,        // room for a word
   output reg [W-1:0] out_data, // head word
   output reg out_valid,        // head word valid
   input wire out_ready         // drain accepts head
);
   reg [W-1:0] spare;
   reg spare_valid;
   wire push;
   wire pop;

   // ready only depends on the spare slot, so a stall never drops a word
   assign in_ready = ~spare_valid;
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // head/spare update; spare moves forward on a pop
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         out_data <= {W{1'b0}};
         out_valid <= 1'b0;
         spare <= {W{1'b0}};
         spare_valid <= 1'b0;
      end else if (pop) begin
         if (spare_valid) begin
            out_data <= spare;
            out_valid <= 1'b1;
            spare <= in_data;
            spare_valid <= push;
         end else begin
            out_data <= in_data;
            out_valid <= push;
         end
      end else if (push) begin
         if (!out_valid) begin
            out_data <= in_data;
            out_valid <= 1'b1;
         end else begin
            spare <= in_data;
            spare_valid <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ### tb/octal_rmii_port_interface_properties.sv
// port assertions for the octal rmii port interface
`timescale 1ns/10ps
`default_nettype none
module octal_rmii_port_interface_properties (
   input wire logic clk, // core clock
   input wire logic rst, // async reset
   input wire logic [15:0] txd, // tx dibits
   input wire logic [7:0] tx_enable_out, // tx enables
   input wire logic [7:0] tx_ready, // byte taken
   input wire logic [7:0] rx_overflow, // byte lost
   input wire logic mdc, // mgmt clock
   input wire logic mdio_o, // mgmt drive value
   input wire logic mdio_oe_n, // low while driving
   input wire logic mgmt_out_bit, // bit to send
   input wire logic mgmt_drive, // own the line
   input wire logic mgmt_in_bit, // sampled bit
   input wire logic mgmt_edge // rise pulse
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   // management clock high for 20 cycles, data moves only at its rise
   chk_mdc_high: assert property ($rose(mdc) |-> ##19 mdc ##1 !mdc)
      else $error("mdc high phase length wrong");
   chk_edge_pulse: assert property (mgmt_edge == $rose(mdc))
      else $error("mgmt edge pulse misplaced");
   chk_mdio_launch: assert property ($rose(mdc) |-> mdio_o == $past(mgmt_out_bit)
      && mdio_oe_n == !$past(mgmt_drive)) else $error("mdio launch wrong");
   chk_mdio_hold: assert property (!$rose(mdc) |-> $stable({mdio_o, mdio_oe_n, mgmt_in_bit}))
      else $error("mdio moved off the rising edge");
   // a ref cycle is over 12 core cycles, so tx lines hold at least 9
   chk_tx_stride: assert property ($changed({txd, tx_enable_out}) |=>
      $stable({txd, tx_enable_out})[*8]) else $error("tx lines changed too soon");
   chk_tx_idle: assert property (tx_enable_out == 8'h00 |-> txd == 16'h0000)
      else $error("tx dibits shown without enable");
   chk_ready_pulse: assert property (tx_ready != 8'h00 |->
      (tx_ready & ~tx_enable_out) == 8'h00 ##1 tx_ready == 8'h00) else $error("tx ready bad");
   chk_ovf_pulse: assert property (rx_overflow != 8'h00 |=> rx_overflow == 8'h00)
      else $error("overflow longer than a cycle");
   cover property (mgmt_edge && !mdio_oe_n);
   cover property (tx_ready[0]);
   cover property (rx_overflow != 8'h00);
endmodule
bind octal_rmii_port_interface octal_rmii_port_interface_properties u_props (
   .clk(clk), .rst(rst), .txd(txd), .tx_enable_out(tx_enable_out), .tx_ready(tx_ready),
   .rx_overflow(rx_overflow), .mdc(mdc), .mdio_o(mdio_o), .mdio_oe_n(mdio_oe_n),
   .mgmt_out_bit(mgmt_out_bit), .mgmt_drive(mgmt_drive), .mgmt_in_bit(mgmt_in_bit),
   .mgmt_edge(mgmt_edge));
`default_nettype wire

// ### tb/rmii_phy_model.sv
// behavioural phy for port a: records tx dibits, plays rx bytes
`timescale 1ns/10ps
`default_nettype none
module rmii_phy_model (
   input wire logic ref_clk, // shared reference
   input wire logic [1:0] txd_a, // tx dibit
   input wire logic tx_en_a, // tx enable
   input wire logic mdc, // mgmt clock
   output logic [1:0] rxd_a = 2'b10, // rx dibit
   output logic crs_dv = 1'b0, // carrier and valid
   output logic mdio_bit = 1'b1 // our mgmt level
);
   logic [1:0] tx_q[$];
   // keep a dibit only while enable is high
   always @(posedge ref_clk) if (tx_en_a) tx_q.push_back(txd_a);
   // new bit just after each rise, so it changes every period
   always @(posedge mdc) mdio_bit <= #2 ~mdio_bit;
   // four bytes lsb dibit first, moved on reference edges only
   task automatic send(input logic [31:0] w);
      int i;
      for (i = 0; i < 16; i++) begin
         @(posedge ref_clk);
         rxd_a <= w[2*i+:2];
         if (i == 0) crs_dv <= #7 1'b1; // carrier arrives off the edge
      end
      @(posedge ref_clk);
      crs_dv <= 1'b0;
      rxd_a <= ~w[31:30]; // idle line must not repeat the last dibit
   endtask
endmodule
`default_nettype wire

// ### tb/octal_rmii_port_interface_test.sv
// self-checking bench for the octal rmii port interface
`timescale 1ns/10ps
`default_nettype none
`include "rmii_regs.vh"
module octal_rmii_port_interface_test;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ref_clk = 1'b0;
   logic [63:0] tx_data = 64'h0;
   logic [7:0] tx_valid = 8'h00;
   logic [7:0] tx_last = 8'h00;
   logic [7:0] rx_ready = 8'h00;
   logic mgmt_out_bit = 1'b0;
   logic mgmt_drive = 1'b0;
   logic [1:0] rxd_a;
   logic crs_dv, mdio_bit, mdc, mdio_o, mdio_oe_n, mgmt_in_bit, mgmt_edge;
   logic [7:0] tx_ready, tx_enable_out, rx_valid, rx_overflow, rx_carrier;
   logic [15:0] txd;
   logic [63:0] rx_data;
   int err_total = 0;
   int n_tests = 0;
   wire logic mdio_i = mdio_oe_n ? mdio_bit : mdio_o; // owner sets the line
   wire logic [2:0] watch = {tx_enable_out[0], tx_ready[0], mgmt_edge};
   // core clock, and a reference unrelated in phase
   always #5 clk = ~clk;
   always #62.5 ref_clk = ~ref_clk;
   octal_rmii_port_interface u_dut (.clk(clk), .rst(rst), .rmii_ref_clock(ref_clk),
      .rxd({8{rxd_a}}), .carrier_rx_valid_in({8{crs_dv}}), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready), .txd(txd),
      .tx_enable_out(tx_enable_out), .rx_data(rx_data), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .rx_overflow(rx_overflow), .rx_carrier(rx_carrier),
      .mdc(mdc), .mdio_o(mdio_o), .mdio_oe_n(mdio_oe_n), .mdio_i(mdio_i),
      .mgmt_out_bit(mgmt_out_bit), .mgmt_drive(mgmt_drive),
      .mgmt_in_bit(mgmt_in_bit), .mgmt_edge(mgmt_edge));
   rmii_phy_model u_phy (.ref_clk(ref_clk), .txd_a(txd[1:0]), .tx_en_a(tx_enable_out[0]),
      .mdc(mdc), .rxd_a(rxd_a), .crs_dv(crs_dv), .mdio_bit(mdio_bit));
   task automatic stop_test;
      if (err_total == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // bounded wait on a watched bit; running out ends the run as a failure
   task automatic wait_on(input int sel, input logic lvl);
      int k;
      for (k = 0; k < 2000; k++) begin
         @(negedge clk);
         if (watch[sel] === lvl) return;
      end
      err_total++;
      stop_test();
   endtask
   task automatic t_mgmt;
      wait_on(0, 1'b1);
      @(posedge clk);
      mgmt_out_bit <= 1'b1;
      mgmt_drive <= 1'b1;
      wait_on(0, 1'b1);
      check("mdio high", 64'h1, {mdio_oe_n, mdio_o});
      @(posedge clk);
      mgmt_out_bit <= 1'b0;
      wait_on(0, 1'b1);
      check("mdio low", 64'h0, {mdio_oe_n, mdio_o});
      @(posedge clk);
      mgmt_drive <= 1'b0;
      wait_on(0, 1'b1);
      check("mdio released", 64'h1, mdio_oe_n);
      repeat (2) begin
         wait_on(0, 1'b1);
         check("mdio sampled", {~mdio_bit}, mgmt_in_bit);
      end
   endtask
   task automatic t_tx_frame;
      logic [7:0] fr[$];
      logic [31:0] crc;
      int i;
      crc = 32'hFFFF_FFFF;
      for (i = 0; i < 7; i++) fr.push_back(`PREAMBLE_BYTE);
      fr.push_back(`SFD_BYTE);
      fr.push_back(8'hA7);
      fr.push_back(8'h3C);
      for (i = 64; i < 80; i++)
         crc = (crc >> 1) ^ ((crc[0] ^ fr[i/8][i%8]) ? `CRC_POLY : 32'h0);
      for (i = 0; i < 4; i++) fr.push_back(~crc[8*i+:8]);
      @(posedge clk);
      tx_data[7:0] <= 8'hA7;
      tx_valid[0] <= 1'b1;
      wait_on(1, 1'b1);
      @(posedge clk);
      tx_data[7:0] <= 8'h3C;
      tx_last[0] <= 1'b1;
      wait_on(1, 1'b1);
      @(posedge clk);
      tx_valid[0] <= 1'b0;
      tx_last[0] <= 1'b0;
      wait_on(2, 1'b0);
      check("tx dibits", 64'h38, u_phy.tx_q.size());
      for (i = 0; i < 56; i++)
         check("tx dibit", fr[i/4][2*(i%4)+:2], u_phy.tx_q[i]);
      check("idle ports", 64'h0, tx_enable_out[7:1]);
   endtask
   // receiver stalled: two bytes buffered, third held pending, fourth overwrites it
   task automatic t_rx_stall;
      int k, lost, car;
      lost = 0;
      car = 0;
      fork
         u_phy.send(32'hC364_9B1E);
      join_none
      for (k = 0; k < 2000 && !(car && rx_carrier === 8'h00); k++) begin
         @(negedge clk);
         lost += (rx_overflow === 8'hFF);
         car |= (rx_carrier === 8'hFF);
      end
      check("overflow pulses", 64'h1, lost);
      check("carrier seen", 64'h1, car);
      check("rx head", {8{8'h1E}}, rx_data);
      for (k = 0; k < 3; k++) begin
         @(posedge clk);
         rx_ready <= 8'hFF;
         @(posedge clk);
         rx_ready <= 8'h00;
         repeat (2) @(negedge clk);
         check("rx valid after pop", (k == 2) ? 64'h0 : 64'hFF, rx_valid);
         if (k < 2) check("rx next", k ? {8{8'hC3}} : {8{8'h9B}}, rx_data);
      end
   endtask
   task automatic t_reset_mid;
      @(posedge clk);
      tx_data[7:0] <= 8'h5A;
      tx_valid[0] <= 1'b1;
      wait_on(2, 1'b1);
      @(posedge clk);
      rst <= 1'b1;
      tx_valid[0] <= 1'b0;
      #1;
      check("reset at once", 64'h2, {txd, tx_enable_out, tx_ready, rx_valid, mdio_oe_n, mdc});
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(negedge clk);
      check("idle after reset", 64'h2, {txd, tx_enable_out, tx_ready, rx_valid, mdio_oe_n, mdc});
   endtask
   // reset for 8 cycles, then the scenarios in turn
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      check("idle outputs", 64'h2, {txd, tx_enable_out, tx_ready, rx_valid, mdio_oe_n, mdc});
      t_mgmt();
      t_tx_frame();
      t_rx_stall();
      t_reset_mid();
      stop_test();
   end
endmodule
`default_nettype wire
